/* hdl/asc_pkg.sv */
// Purpose: constants for the async sram host controller
// Assumes: 250 MHz ref_clk, 20 ns speed grade by default
// Notes: times in ns, cycle counts derived from them
package asc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int WORDS = 262144;
  // 20 ns grade
  localparam int READ_CYCLE_NS = 20;
  localparam int SELECT_TO_WRITE_END_NS = 12;
  localparam int ADDR_VALID_TO_WRITE_END_NS = 12;
  localparam int ADDR_HOLD_AFTER_WRITE_NS = 0;
  localparam int OUTPUT_OFF_FLOAT_NS = 6;
  localparam int WRITE_FLOAT_NS = 8;
  localparam int DESELECT_FLOAT_NS = 8;
  localparam int DATA_SETUP_NS = 8;
  // least times round up to whole cycles
  localparam int RD_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC_RAW =
    (ADDR_VALID_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CW_CYC =
    (SELECT_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (WR_CYC_RAW > CW_CYC) ? WR_CYC_RAW : CW_CYC;
  localparam int FLT_RAW = (OUTPUT_OFF_FLOAT_NS > DESELECT_FLOAT_NS) ?
    OUTPUT_OFF_FLOAT_NS : DESELECT_FLOAT_NS;
  localparam int FLT_CYC = (FLT_RAW + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
endpackage

/* hdl/asc_delay_counter.sv */
// Purpose: down counter for timed phases
// Assumes: load has priority over counting
// Notes: done is high while count is zero
`timescale 1ns/1ps
`default_nettype none
module asc_delay_counter #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic done
);
  logic [WIDTH-1:0] count_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= loadValue;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end
  assign done = (count_reg == '0);
endmodule
`default_nettype wire

/* hdl/asc_sram_host.sv */
// Purpose: host controller for a 256K x 32 asynchronous sram module
// Assumes: one clock, requests held until accepted
// Notes: one access at a time, all pin outputs registered
// Operation
// - write spans later fall to earlier rise
// - address read keeps selects active
// - address valid by last select
// - select held 12 ns before write end
// - address valid 12 ns before write end
// - address may change at write end
`timescale 1ns/1ps
`default_nettype none
module asc_sram_host #(
  parameter int ADDR_W = asc_pkg::ADDR_W,
  parameter int DATA_W = asc_pkg::DATA_W,
  parameter int LANES = asc_pkg::LANES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqWdata,
  input wire logic [LANES-1:0] reqLanes,
  output logic reqReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspRdata,
  output logic [1:0] densityId,
  output logic [ADDR_W-1:0] word_address_lines,
  output logic [LANES-1:0] byte_lane_select_n,
  output logic writeStrobe_n,
  output logic outputEnable_n,
  input wire logic [DATA_W-1:0] dataLinesIn,
  output logic [DATA_W-1:0] dataLinesOut,
  output logic [DATA_W-1:0] dataLinesOe,
  input wire logic density_id_bit0,
  input wire logic density_id_bit1
);
  typedef enum logic [2:0] {
    ASC_IDLE = 3'b000,
    ASC_RD = 3'b001,
    ASC_WFLT = 3'b010,
    ASC_WR = 3'b011,
    ASC_END = 3'b100
  } asc_state_t;

  typedef struct packed {
    asc_state_t st;
    logic ready;
    logic rsp;
    logic [DATA_W-1:0] rdata;
    logic [1:0] dens;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] sel_n;
    logic we_n;
    logic oe_n;
    logic [DATA_W-1:0] dout;
    logic drive;
  } asc_regs_t;

  asc_regs_t s_reg;
  asc_regs_t s_next;
  logic cntLoad;
  logic [asc_pkg::CNT_W-1:0] cntValue;
  logic cntDone;

  asc_delay_counter #(.WIDTH(asc_pkg::CNT_W)) u_cnt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(cntLoad),
    .loadValue(cntValue),
    .done(cntDone)
  );

  always_comb begin
    s_next = s_reg;
    cntLoad = 1'b0;
    cntValue = '0;
    s_next.rsp = 1'b0;
    s_next.ready = 1'b0;
    s_next.dens = {density_id_bit1, density_id_bit0};
    case (s_reg.st)
      ASC_IDLE: begin
        s_next.ready = 1'b1;
        if (s_reg.ready && reqValid) begin
          s_next.ready = 1'b0;
          s_next.addr = reqAddr;
          s_next.sel_n = ~reqLanes;
          if (reqWrite) begin
            s_next.dout = reqWdata;
            s_next.oe_n = 1'b1;
            s_next.st = ASC_WFLT;
            cntLoad = 1'b1;
            cntValue = asc_pkg::CNT_W'(asc_pkg::FLT_CYC);
          end else begin
            s_next.oe_n = 1'b0;
            s_next.st = ASC_RD;
            cntLoad = 1'b1;
            cntValue = asc_pkg::CNT_W'(asc_pkg::RD_CYC);
          end
        end
      end
      ASC_RD: begin
        if (cntDone) begin
          s_next.rdata = dataLinesIn;
          s_next.rsp = 1'b1;
          s_next.sel_n = '1;
          s_next.oe_n = 1'b1;
          s_next.st = ASC_END;
          cntLoad = 1'b1;
          cntValue = asc_pkg::CNT_W'(asc_pkg::FLT_CYC);
        end
      end
      ASC_WFLT: begin
        if (cntDone) begin
          s_next.drive = 1'b1;
          s_next.we_n = 1'b0;
          s_next.st = ASC_WR;
          cntLoad = 1'b1;
          cntValue = asc_pkg::CNT_W'(asc_pkg::WR_CYC);
        end
      end
      ASC_WR: begin
        if (cntDone) begin
          s_next.we_n = 1'b1;
          s_next.sel_n = '1;
          s_next.st = ASC_END;
        end
      end
      ASC_END: begin
        s_next.drive = 1'b0;
        if (cntDone) begin
          s_next.st = ASC_IDLE;
          s_next.ready = 1'b1;
        end
      end
      default: begin
        s_next.st = ASC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: ASC_IDLE, ready: 1'b0, rsp: 1'b0, rdata: '0, dens: 2'h0,
                 addr: '0, sel_n: '1, we_n: 1'b1, oe_n: 1'b1, dout: '0,
                 drive: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign reqReady = s_reg.ready;
  assign rspValid = s_reg.rsp;
  assign rspRdata = s_reg.rdata;
  assign densityId = s_reg.dens;
  assign word_address_lines = s_reg.addr;
  assign byte_lane_select_n = s_reg.sel_n;
  assign writeStrobe_n = s_reg.we_n;
  assign outputEnable_n = s_reg.oe_n;
  assign dataLinesOut = s_reg.dout;
  assign dataLinesOe = {DATA_W{s_reg.drive}};

  chk_no_contention: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_reg.drive |-> s_reg.oe_n)
    else $error("host drives data while output enabled");
  chk_write_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_reg.we_n |-> (s_reg.sel_n != '1) && s_reg.drive)
    else $error("write strobe without select or data");
  chk_write_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(s_reg.we_n) |-> !s_reg.we_n [*3])
    else $error("write pulse too short");
  chk_addr_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_reg.we_n |=> $stable(s_reg.addr) || s_reg.we_n)
    else $error("address moved during write");
  chk_read_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(s_reg.oe_n) |-> !s_reg.oe_n [*5])
    else $error("read ended early");
  chk_float_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(s_reg.drive) |-> s_reg.oe_n && $past(s_reg.oe_n, 2) && ($past(s_reg.st, 2) == ASC_WFLT))
    else $error("drive before float");
  chk_read_response: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(s_reg.oe_n) && s_reg.rsp |-> $past(s_reg.st) == ASC_RD)
    else $error("response without read");
  chk_dens_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> s_reg.dens == $past({density_id_bit1, density_id_bit0}))
    else $error("density id not sampled");
endmodule
`default_nettype wire

/* tb/asc_sram_model.sv */
// Purpose: behavioural 256K x 32 memory module
// Assumes: zero delay, lanes independent
// Notes: undriven lanes show inverse of last level
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model #(
  parameter logic [1:0] DENSITY = 2'h2 // arbitrary value
) (
  input wire logic [17:0] word_address_lines,
  input wire logic [3:0] byte_lane_select_n,
  input wire logic writeStrobe_n,
  input wire logic outputEnable_n,
  input wire logic [31:0] hostOut,
  input wire logic [31:0] hostOe,
  output logic [31:0] dataLinesIn,
  output logic density_id_bit0,
  output logic density_id_bit1
);
  bit [31:0] memArr [int];
  bit [31:0] rd;
  logic [31:0] lastVal = 32'h0;
  assign density_id_bit0 = DENSITY[0];
  assign density_id_bit1 = DENSITY[1];
  always @(word_address_lines or byte_lane_select_n or writeStrobe_n or outputEnable_n
      or hostOut or hostOe) begin
    for (int i = 0; i < 4; i++) begin
      rd = memArr.exists(word_address_lines) ? memArr[word_address_lines] : 32'h0;
      if (!byte_lane_select_n[i] && !writeStrobe_n) begin
        rd[8*i +: 8] = hostOut[8*i +: 8];
        memArr[word_address_lines] = rd;
      end
      if (hostOe[8*i])
        dataLinesIn[8*i +: 8] = hostOut[8*i +: 8];
      else if (!byte_lane_select_n[i] && writeStrobe_n && !outputEnable_n)
        dataLinesIn[8*i +: 8] = rd[8*i +: 8];
      else
        dataLinesIn[8*i +: 8] = ~lastVal[8*i +: 8];
    end
    lastVal = dataLinesIn;
  end
endmodule
`default_nettype wire

/* tb/test_async_sram_module_256kx32.sv */
// Purpose: self-checking bench for the sram host controller
// Assumes: model memory starts at zero
// Notes: only selected lanes are compared
`timescale 1ns/1ps
`default_nettype none
module test_async_sram_module_256kx32;
  logic ref_clk, rst_n, reqValid, reqWrite, reqReady, rspValid, weN, oeN, idBit0, idBit1;
  logic [17:0] reqAddr, addrLines;
  logic [31:0] reqWdata, rspRdata, dIn, dOut, dOe, lfsr;
  logic [3:0] reqLanes, selN;
  logic [1:0] densityId;
  int err_total, n_checks;
  bit [31:0] refMem [int];
  asc_sram_host DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqLanes(reqLanes),
    .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata), .densityId(densityId),
    .word_address_lines(addrLines), .byte_lane_select_n(selN), .writeStrobe_n(weN),
    .outputEnable_n(oeN), .dataLinesIn(dIn), .dataLinesOut(dOut), .dataLinesOe(dOe),
    .density_id_bit0(idBit0), .density_id_bit1(idBit1));
  asc_sram_model mem (.word_address_lines(addrLines), .byte_lane_select_n(selN),
    .writeStrobe_n(weN), .outputEnable_n(oeN), .hostOut(dOut), .hostOe(dOe),
    .dataLinesIn(dIn), .density_id_bit0(idBit0), .density_id_bit1(idBit1));
  // bus watch at mid cycle, where pins are settled
  always @(negedge ref_clk) begin
    if (rst_n) begin
      check({31'h0, dOe[0] & ~oeN}, 32'h0);
      check({31'h0, ~weN & (&selN | ~dOe[0])}, 32'h0);
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic access(input bit wr, input logic [17:0] a, input logic [31:0] d,
      input logic [3:0] ln);
    int n;
    logic [31:0] m, e;
    m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    e = refMem.exists(a) ? refMem[a] : 32'h0;
    n = 0;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = d;
    reqLanes = ln;
    while (reqReady !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check({31'h0, reqReady}, 32'h1);
    @(posedge ref_clk);
    #1 reqValid = 1'b0;
    if (wr) begin
      refMem[a] = (e & ~m) | (d & m);
      @(posedge ref_clk);
      #1;
    end else begin
      n = 0;
      while (rspValid !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        #1 n++;
      end
      check({31'h0, rspValid}, 32'h1);
      check(n, asc_pkg::RD_CYC + 1);
      check({27'h0, selN, oeN}, 32'h1f);
      check(rspRdata & m, e & m);
    end
  endtask
  initial begin
    #40000 err_total++;
    end_sim();
  end
  initial begin
    {rst_n, reqValid, reqWrite, reqAddr, reqWdata, reqLanes} = '0;
    err_total = 0;
    n_checks = 0;
    lfsr = 32'h24;
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    @(posedge ref_clk);
    #1 check({30'h0, densityId}, 32'h2);
    check({26'h0, selN, weN, oeN}, 32'h3f);
    $display("density test done");
    access(1, 18'h0, 32'h11223344, 4'hf);
    access(1, 18'h3ffff, 32'ha5c3e781, 4'hf);
    access(0, 18'h3ffff, 32'h0, 4'hf);
    access(0, 18'h0, 32'h0, 4'hf);
    $display("boundary test done");
    for (int i = 0; i < 4; i++) begin
      access(1, 18'h5, 32'hffffffff, 4'hf);
      access(1, 18'h5, 32'h0, 4'h1 << i);
      access(0, 18'h5, 32'h0, 4'hf);
    end
    $display("lane test done");
    for (int i = 0; i < 40; i++) begin
      lfsr = step(lfsr);
      access(lfsr[0], {15'h0, lfsr[3:1]}, step(lfsr), lfsr[7:4] | 4'h1);
      check({31'h0, dOe[0]}, 32'h0);
      check({31'h0, &selN | oeN}, 32'h1);
    end
    $display("random test done");
    end_sim();
  end
endmodule
`default_nettype wire
